// File: src/aea_regs.svh
// Register indices, field positions, reset values and timing constants
`ifndef AEA_REGS_SVH
`define AEA_REGS_SVH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define AEA_IDX_ENERGY 8'h01
`define AEA_IDX_ENERGY_RC 8'h02
`define AEA_IDX_LINE_ENERGY 8'h03
`define AEA_IDX_WAV_SRC 8'h0D
`define AEA_IDX_NL_SEL 8'h0E
`define AEA_IDX_ACC_MODE 8'h0F
`define AEA_IDX_HALF_CYC 8'h12
`define AEA_IDX_GAIN 8'h1D
`define AEA_IDX_DIVIDER 8'h24
`define AEA_IDX_EN_LOW 8'hD9
`define AEA_IDX_EN_MID 8'hDA
`define AEA_IDX_EN_HIGH 8'hDB
`define AEA_IDX_ST_LOW 8'hDC
`define AEA_IDX_ST_MID 8'hDD
`define AEA_IDX_ST_HIGH 8'hDE
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AEA_NO_LOAD_BIT 0
`define AEA_SIGN_BIT 3
`define AEA_HALF_BIT 0
`define AEA_OVF_BIT 1
`define AEA_CYC_END_BIT 2
`define AEA_WAVE_EN_BIT 5
`define AEA_ABS_BIT 0
`define AEA_POS_BIT 1
`define AEA_SIGN_DIR_BIT 4
`define AEA_LINE_EN_BIT 7
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define AEA_RST_BYTE 8'h00
`define AEA_CLK_HZ 20000000
`define AEA_SAMPLE_CYC 16'h0005
`define AEA_WAVE_SPS 25600
`define AEA_FULL_SCALE 32'h000CCCCD
`define AEA_PULSE_TH 32'h01000000
`define AEA_PULSE_NS 10000
`endif

// File: src/aea_pkg.sv
// Types shared by the active energy accumulator modules
package aea_pkg;
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } aea_tick_t;

    typedef struct packed {
        logic [48:0] acc;
        logic [48:0] line_acc;
        logic [23:0] line_energy;
        logic [15:0] hc_cnt;
        logic line_arm;
        logic [7:0] wav_src;
        logic [7:0] nl_sel;
        logic [7:0] acc_mode;
        logic [15:0] half_cyc;
        logic [11:0] gain;
        logic [7:0] divider;
        logic [7:0] en_l;
        logic [7:0] en_m;
        logic [7:0] en_h;
        logic [7:0] st_l;
        logic [7:0] st_m;
        logic [7:0] st_h;
        logic prev_neg;
        logic [31:0] pulse_acc;
        logic [15:0] pulse_cnt;
        logic pulse_n;
        logic irq;
        logic [23:0] wav;
        logic wav_v;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } aea_state_t;
endpackage

// File: src/aea_tick.sv
// One-cycle enable pulse every period clock cycles
`timescale 1ns/1ps
module aea_tick (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Period in cycles, zero acts as one
    input wire logic [15:0] period,
    // Enable pulse
    output logic tick
);
    aea_pkg::aea_tick_t s_r;
    aea_pkg::aea_tick_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt + 16'h0001 >= period) begin
            s_nxt.cnt = 16'h0000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

    a_tick_single: assert property (@(posedge clock) disable iff (rst)
        tick && period > 16'h0001 |=> !tick)
        else $error("tick lasted more than one cycle");
endmodule

// File: src/aea_top.sv
// Active energy accumulator with APB register file and line-cycle mode
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "aea_regs.svh"
module aea_top #(
    parameter int WAVE_CYC = `AEA_CLK_HZ / `AEA_WAVE_SPS,
    parameter logic [31:0] PULSE_TH = `AEA_PULSE_TH,
    parameter logic [31:0] FULL_SCALE = `AEA_FULL_SCALE
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Calibrated power samples and voltage zero crossing
    input wire logic [23:0] active_power,
    input wire logic zero_cross,
    // Outputs
    output logic energy_pulse_out_n,
    output logic measure_irq,
    output logic [23:0] wave_sample,
    output logic wave_valid
);
    localparam logic [15:0] PULSE_CYC =
        16'((`AEA_PULSE_NS * 20 + 999) / 1000);

    aea_pkg::aea_state_t s_r;
    aea_pkg::aea_state_t s_nxt;

    logic smp_tick;
    logic wav_tick;
    logic [15:0] wav_period;
    logic signed [35:0] prod;
    logic signed [25:0] gained;
    logic signed [9:0] dvs;
    logic signed [25:0] divided;
    logic signed [25:0] inc;
    logic signed [25:0] pul;
    logic [25:0] g_mag;
    logic [25:0] pul_mag;
    logic below;
    logic pos_mode;
    logic abs_mode;
    logic acc_phase;
    logic addr_ok;
    logic [7:0] idx;
    logic wr_evt;
    logic rc_evt;
    logic lc_wr;
    logic line_end;
    logic pulse_start;
    logic [48:0] acc_base;
    logic [48:0] acc_new;
    logic [23:0] energy_top;
    logic [32:0] rd_word;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] nl_thresh(input logic [1:0] sel);
        unique case (sel)
            2'h1: nl_thresh = 32'((FULL_SCALE * 15) / 100000);
            2'h2: nl_thresh = 32'((FULL_SCALE * 75) / 1000000);
            2'h3: nl_thresh = 32'((FULL_SCALE * 37) / 1000000);
            2'h0: nl_thresh = 32'h00000000;
        endcase
    endfunction

    function automatic logic signed [25:0] apply_mode(
        input logic signed [25:0] v, input logic po, input logic ab);
        if (po) begin
            apply_mode = v[25] ? 26'sh0000000 : v;
        end else if (ab) begin
            apply_mode = v[25] ? -v : v;
        end else begin
            apply_mode = v;
        end
    endfunction

    function automatic logic [32:0] rd_mux(input logic [7:0] i,
        input aea_pkg::aea_state_t st);
        rd_mux = {1'b1, 32'h00000000};
        case (i)
            `AEA_IDX_ENERGY, `AEA_IDX_ENERGY_RC:
                rd_mux[23:0] = st.acc[48:25];
            `AEA_IDX_LINE_ENERGY: rd_mux[23:0] = st.line_energy;
            `AEA_IDX_WAV_SRC: rd_mux[7:0] = st.wav_src;
            `AEA_IDX_NL_SEL: rd_mux[7:0] = st.nl_sel;
            `AEA_IDX_ACC_MODE: rd_mux[7:0] = st.acc_mode;
            `AEA_IDX_HALF_CYC: rd_mux[15:0] = st.half_cyc;
            `AEA_IDX_GAIN: rd_mux[11:0] = st.gain;
            `AEA_IDX_DIVIDER: rd_mux[7:0] = st.divider;
            `AEA_IDX_EN_LOW: rd_mux[7:0] = st.en_l;
            `AEA_IDX_EN_MID: rd_mux[7:0] = st.en_m;
            `AEA_IDX_EN_HIGH: rd_mux[7:0] = st.en_h;
            `AEA_IDX_ST_LOW: rd_mux[7:0] = st.st_l;
            `AEA_IDX_ST_MID: rd_mux[7:0] = st.st_m;
            `AEA_IDX_ST_HIGH: rd_mux[7:0] = st.st_h;
            default: rd_mux[32] = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Sample and waveform rate enables
    // ------------------------------------------------------------------
    // five-clock sample enable
    aea_tick u_smp (
        .clock(clock),
        .rst(rst),
        .period(`AEA_SAMPLE_CYC),
        .tick(smp_tick)
    );

    // rate halves per step of the rate field
    assign wav_period = 16'(WAVE_CYC) << s_r.wav_src[4:3];

    aea_tick u_wav (
        .clock(clock),
        .rst(rst),
        .period(wav_period),
        .tick(wav_tick)
    );

    // ------------------------------------------------------------------
    // Power path
    // ------------------------------------------------------------------
    // gain of one plus gain/4096
    assign prod = $signed(active_power) * $signed(s_r.gain);
    assign gained = 26'($signed(active_power)) + 26'(prod >>> 12);
    assign dvs = (s_r.divider == 8'h00) ? 10'sh001
                                         : $signed({2'b00, s_r.divider});
    assign divided = gained / 26'(dvs);
    assign g_mag = gained[25] ? 26'(-gained) : 26'(gained);
    assign below = (s_r.nl_sel[1:0] != 2'h0) &&
                   (32'(g_mag) < nl_thresh(s_r.nl_sel[1:0]));
    // both mode bits set fall back to positive-only
    assign pos_mode = s_r.acc_mode[`AEA_POS_BIT];
    assign abs_mode = s_r.acc_mode[`AEA_ABS_BIT] & ~pos_mode;
    assign inc = below ? 26'sh0000000
                       : apply_mode(divided, pos_mode, abs_mode);
    // pulse path follows gain and mode, not the divider
    assign pul = below ? 26'sh0000000
                       : apply_mode(gained, pos_mode, abs_mode);
    assign pul_mag = pul[25] ? 26'(-pul) : 26'(pul);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign acc_phase = psel & penable & ~s_r.pready;
    assign wr_evt = psel & penable & s_r.pready & pwrite & addr_ok;
    // Clear happens with the data capture, so nothing added later is lost
    assign rc_evt = acc_phase & ~pwrite & addr_ok &
                    (idx == `AEA_IDX_ENERGY_RC);
    assign lc_wr = wr_evt & (idx == `AEA_IDX_HALF_CYC);
    assign rd_word = rd_mux(idx, s_r);

    // read-clear keeps only the hidden low bits
    assign acc_base = rc_evt ? {24'h000000, s_r.acc[24:0]} : s_r.acc;
    // two's complement wrap of the whole accumulator
    assign acc_new = acc_base + 49'(inc);
    assign energy_top = s_r.acc[48:25];

    assign line_end = s_r.acc_mode[`AEA_LINE_EN_BIT] & ~lc_wr &
                      zero_cross & s_r.line_arm &
                      (s_r.half_cyc != 16'h0000) &&
                      (s_r.hc_cnt + 16'h0001 == s_r.half_cyc);
    assign pulse_start = smp_tick &&
                         (s_r.pulse_acc + 32'(pul_mag) >= PULSE_TH);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.wav_v = 1'b0;
        s_nxt.pready = acc_phase;
        if (acc_phase) begin
            s_nxt.pslverr = ~(addr_ok & rd_word[32]);
            s_nxt.prdata = pwrite ? 32'h00000000 : rd_word[31:0];
        end
        if (rc_evt) begin
            s_nxt.acc = acc_base;
        end
        if (wr_evt) begin
            case (idx)
                `AEA_IDX_WAV_SRC: s_nxt.wav_src = pwdata[7:0];
                `AEA_IDX_NL_SEL: s_nxt.nl_sel = pwdata[7:0];
                `AEA_IDX_ACC_MODE: s_nxt.acc_mode = pwdata[7:0];
                `AEA_IDX_HALF_CYC: s_nxt.half_cyc = pwdata[15:0];
                `AEA_IDX_GAIN: s_nxt.gain = pwdata[11:0];
                `AEA_IDX_DIVIDER: s_nxt.divider = pwdata[7:0];
                `AEA_IDX_EN_LOW: s_nxt.en_l = pwdata[7:0];
                `AEA_IDX_EN_MID: s_nxt.en_m = pwdata[7:0];
                `AEA_IDX_EN_HIGH: s_nxt.en_h = pwdata[7:0];
                `AEA_IDX_ST_LOW: s_nxt.st_l = s_r.st_l & ~pwdata[7:0];
                `AEA_IDX_ST_MID: s_nxt.st_m = s_r.st_m & ~pwdata[7:0];
                `AEA_IDX_ST_HIGH: s_nxt.st_h = s_r.st_h & ~pwdata[7:0];
                default: s_nxt.gain = s_r.gain;
            endcase
        end
        // Flag sets come after the clears so a same-cycle event wins
        if (smp_tick) begin
            s_nxt.acc = acc_new;
            if (below) begin
                s_nxt.st_l[`AEA_NO_LOAD_BIT] = 1'b1;
            end
            // sign change in the selected direction
            s_nxt.prev_neg = gained[25];
            if (s_r.acc_mode[`AEA_SIGN_DIR_BIT] ?
                (s_r.prev_neg & ~gained[25]) :
                (~s_r.prev_neg & gained[25])) begin
                s_nxt.st_l[`AEA_SIGN_BIT] = 1'b1;
            end
            // half full either sign, overflow or underflow
            if ((acc_base[48:47] == 2'b00 && acc_new[48:47] == 2'b01) ||
                (acc_base[48:47] == 2'b11 && acc_new[48:47] == 2'b10)) begin
                s_nxt.st_m[`AEA_HALF_BIT] = 1'b1;
            end
            // Same-sign operands giving the other sign is a wrap
            if (acc_base[48] != acc_new[48] &&
                acc_base[48] == inc[25]) begin
                s_nxt.st_m[`AEA_OVF_BIT] = 1'b1;
            end
            s_nxt.pulse_acc = s_r.pulse_acc + 32'(pul_mag);
            if (pulse_start) begin
                s_nxt.pulse_acc = s_r.pulse_acc + 32'(pul_mag) - PULSE_TH;
            end
        end
        if (pulse_start) begin
            s_nxt.pulse_cnt = PULSE_CYC;
            s_nxt.pulse_n = 1'b0;
        end else if (s_r.pulse_cnt > 16'h0001) begin
            s_nxt.pulse_cnt = s_r.pulse_cnt - 16'h0001;
        end else begin
            s_nxt.pulse_cnt = 16'h0000;
            s_nxt.pulse_n = 1'b1;
        end
        // count write clears result and waits for a crossing
        if (lc_wr) begin
            s_nxt.line_energy = 24'h000000;
            s_nxt.line_acc = 49'h0;
            s_nxt.line_arm = 1'b0;
            s_nxt.hc_cnt = 16'h0000;
        end else if (s_r.acc_mode[`AEA_LINE_EN_BIT]) begin
            // same increment and weight as main sum
            if (smp_tick && s_r.line_arm) begin
                s_nxt.line_acc = s_r.line_acc + 49'(inc);
            end
            if (zero_cross) begin
                if (!s_r.line_arm) begin
                    s_nxt.line_arm = 1'b1;
                    s_nxt.hc_cnt = 16'h0000;
                    s_nxt.line_acc = 49'h0;
                end else if (line_end) begin
                    s_nxt.line_energy = s_nxt.line_acc[48:25];
                    s_nxt.st_h[`AEA_CYC_END_BIT] = 1'b1;
                    s_nxt.line_acc = 49'h0;
                    s_nxt.hc_cnt = 16'h0000;
                end else begin
                    s_nxt.hc_cnt = s_r.hc_cnt + 16'h0001;
                end
            end
        end
        if (wav_tick && s_r.en_h[`AEA_WAVE_EN_BIT] &&
            s_r.wav_src[1:0] == 2'h0) begin
            s_nxt.wav = 24'(gained);
            s_nxt.wav_v = 1'b1;
        end
        s_nxt.irq = |(s_r.st_l & s_r.en_l) | |(s_r.st_m & s_r.en_m) |
            (s_r.st_h[`AEA_CYC_END_BIT] & s_r.en_h[`AEA_CYC_END_BIT]);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.pulse_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign energy_pulse_out_n = s_r.pulse_n;
    assign measure_irq = s_r.irq;
    assign wave_sample = s_r.wav;
    assign wave_valid = s_r.wav_v;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence smp_gap;
        !smp_tick [*4] ##1 smp_tick;
    endsequence
    sequence pulse_low;
        !energy_pulse_out_n [*4];
    endsequence
    sequence apb_answer;
        pready ##1 !pready;
    endsequence

    a_sample_every_five: assert property (smp_tick |=> smp_gap)
        else $error("sample enable not every five cycles");
    a_no_load_hold: assert property (smp_tick && below && !rc_evt
        |=> s_r.acc == $past(s_r.acc))
        else $error("energy changed under no-load");
    a_no_load_flag: assert property (smp_tick && below
        |=> s_r.st_l[`AEA_NO_LOAD_BIT])
        else $error("no-load flag not set");
    a_irq_follows: assert property (s_r.st_l[0] && s_r.en_l[0]
        |=> measure_irq)
        else $error("interrupt missing for enabled flag");
    a_pos_only_neg: assert property (smp_tick && pos_mode &&
        gained[25] && !rc_evt |=> s_r.acc == $past(s_r.acc))
        else $error("negative power accumulated in positive-only");
    a_read_clear: assert property (rc_evt
        |=> prdata[23:0] == $past(energy_top))
        else $error("read-clear returned wrong energy");
    a_sign_flag: assert property (smp_tick && !s_r.acc_mode[4] &&
        !s_r.prev_neg && gained[25] |=> s_r.st_l[`AEA_SIGN_BIT])
        else $error("sign flag not set on falling power");
    a_cycle_end: assert property (line_end
        |=> s_r.st_h[`AEA_CYC_END_BIT] && s_r.hc_cnt == 16'h0000)
        else $error("cycle end not flagged");
    a_count_write: assert property (lc_wr
        |=> s_r.line_energy == 24'h000000 && !s_r.line_arm)
        else $error("count write did not clear line energy");
    a_pulse_width: assert property (pulse_start |=> pulse_low)
        else $error("energy pulse too short");
    a_apb_ready: assert property (acc_phase |=> apb_answer)
        else $error("apb answer not one wait state");
endmodule

// File: verification/aea_cpu.sv
// Processor core model: APB master that services the register file
`timescale 1ns/1ps
module aea_cpu (
    // Clock
    input wire logic clock,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic err_r = 1'b0;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // Request held until pready is sampled; one idle cycle keeps the
    // next setup off the releasing edge
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic clear_flags(input logic [7:0] idx, input logic [7:0] m);
        logic [31:0] x;
        xfer(1'b1, idx, {24'h000000, m}, x);
    endtask
endmodule

// File: verification/active_energy_accumulator_tb.sv
// Self-checking testbench of the active energy accumulator
`timescale 1ns/1ps
`include "aea_regs.svh"
module active_energy_accumulator_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [23:0] active_power = 24'h000000;
    logic zero_cross = 1'b0;
    logic energy_pulse_out_n, measure_irq, wave_valid;
    logic [23:0] wave_sample;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    localparam logic [23:0] P21 = 24'h200000;
    localparam logic [23:0] N21 = 24'hE00000;

    always #25 clock = ~clock;

    // Small pulse threshold and waveform period keep the run short
    aea_top #(.WAVE_CYC(8), .PULSE_TH(32'h00000100)) u_dut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .active_power(active_power), .zero_cross(zero_cross),
        .energy_pulse_out_n(energy_pulse_out_n),
        .measure_irq(measure_irq), .wave_sample(wave_sample),
        .wave_valid(wave_valid)
    );
    aea_cpu u_cpu (
        .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic results();
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic signed [23:0] got, input int lo,
                           input int hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errors++;
            $display("Error at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        u_cpu.xfer(1'b1, idx, d, r);
    endtask
    task automatic rd(input logic [7:0] idx);
        u_cpu.xfer(1'b0, idx, 32'h00000000, r);
    endtask
    // Energy change over 800 clocks, about 160 samples
    task automatic measure(input int lo, input int hi);
        logic [23:0] e0;
        rd(`AEA_IDX_ENERGY);
        e0 = r[23:0];
        repeat (800) @(posedge clock);
        rd(`AEA_IDX_ENERGY);
        chk_rng(r[23:0] - e0, lo, hi);
    endtask
    task automatic acc_case(input logic [7:0] m, input logic [7:0] dv,
                            input logic [11:0] g, input logic [23:0] p,
                            input int lo, input int hi);
        wr(`AEA_IDX_ACC_MODE, {24'h000000, m});
        wr(`AEA_IDX_DIVIDER, {24'h000000, dv});
        wr(`AEA_IDX_GAIN, {20'h00000, g});
        active_power <= p;
        measure(lo, hi);
    endtask
    task automatic nl_case(input logic [1:0] s, input logic [23:0] p,
                           input logic f);
        wr(`AEA_IDX_NL_SEL, {30'h00000000, s});
        active_power <= p;
        repeat (10) @(posedge clock);
        u_cpu.clear_flags(`AEA_IDX_ST_LOW, 8'h01);
        repeat (20) @(posedge clock);
        rd(`AEA_IDX_ST_LOW);
        chk(r & 32'h00000001, {31'h00000000, f});
    endtask
    task automatic low_cycles(output int n);
        n = 0;
        repeat (300) begin
            @(posedge clock);
            if (energy_pulse_out_n === 1'b0) n++;
        end
    endtask
    // Cycles between two waveform strobes
    task automatic wave_gap(output int n);
        int k;
        k = 0;
        while (wave_valid !== 1'b1 && k < 100) begin
            @(posedge clock);
            k++;
        end
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wave_valid !== 1'b1 && n < 100);
    endtask
    // Half line cycles of 200 clocks
    task automatic zc(input int n);
        repeat (n) begin
            repeat (199) @(posedge clock);
            zero_cross <= 1'b1;
            @(posedge clock);
            zero_cross <= 1'b0;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_regs();
        rd(`AEA_IDX_ENERGY);
        chk(r, 32'h00000000);
        rd(`AEA_IDX_ACC_MODE);
        chk(r, 32'h00000000);
        wr(`AEA_IDX_GAIN, 32'h000007FF);
        rd(`AEA_IDX_GAIN);
        chk(r, 32'h000007FF);
        rd(8'h50);
        chk({31'h00000000, u_cpu.err_r}, 32'h00000001);
    endtask
    task automatic s_accum();
        acc_case(8'h00, 8'h00, 12'h000, P21, 9, 11);
        acc_case(8'h00, 8'h00, 12'h000, N21, -11, -9);
        rd(`AEA_IDX_ST_LOW);
        chk(r & 32'h00000008, 32'h00000008);
        acc_case(8'h02, 8'h00, 12'h000, N21, 0, 0);
        acc_case(8'h01, 8'h00, 12'h000, N21, 9, 11);
        acc_case(8'h03, 8'h00, 12'h000, N21, 0, 0);
        acc_case(8'h00, 8'h02, 12'h000, P21, 4, 6);
        acc_case(8'h00, 8'h00, 12'h7FF, P21, 14, 16);
        acc_case(8'h00, 8'h00, 12'h800, P21, 4, 6);
        wr(`AEA_IDX_GAIN, 32'h00000000);
    endtask
    task automatic s_read_clear();
        logic [23:0] e0;
        rd(`AEA_IDX_ENERGY);
        e0 = r[23:0];
        rd(`AEA_IDX_ENERGY_RC);
        chk_rng(r[23:0] - e0, 0, 1);
        rd(`AEA_IDX_ENERGY);
        chk_rng(r[23:0], 0, 1);
    endtask
    task automatic s_no_load();
        nl_case(2'h0, 24'h000064, 1'b0);
        nl_case(2'h1, 24'h000064, 1'b1);
        nl_case(2'h2, 24'h000064, 1'b0);
        nl_case(2'h2, 24'h000032, 1'b1);
        nl_case(2'h3, 24'h000032, 1'b0);
        nl_case(2'h3, 24'h000014, 1'b1);
        measure(0, 0);
        wr(`AEA_IDX_EN_LOW, 32'h00000001);
        repeat (3) @(posedge clock);
        chk({31'h00000000, measure_irq}, 32'h00000001);
        active_power <= P21;
        repeat (10) @(posedge clock);
        u_cpu.clear_flags(`AEA_IDX_ST_LOW, 8'h09);
        repeat (3) @(posedge clock);
        chk({31'h00000000, measure_irq}, 32'h00000000);
        wr(`AEA_IDX_EN_LOW, 32'h00000000);
    endtask
    task automatic s_pulse_wave();
        int n;
        // Reset drains the pulse backlog left by the large powers above
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk({31'h00000000, energy_pulse_out_n}, 32'h00000001);
        wr(`AEA_IDX_NL_SEL, 32'h00000003);
        active_power <= 24'h000014;
        repeat (250) @(posedge clock);
        low_cycles(n);
        chk(n, 32'h00000000);
        wr(`AEA_IDX_NL_SEL, 32'h00000000);
        low_cycles(n);
        chk({31'h00000000, n > 0}, 32'h00000001);
        active_power <= 24'h123456;
        wr(`AEA_IDX_EN_HIGH, 32'h00000020);
        n = 0;
        while (wave_valid !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        chk({8'h00, wave_sample}, 32'h00123456);
        wr(`AEA_IDX_WAV_SRC, 32'h00000008);
        wave_gap(n);
        chk(n, 32'h00000010);
    endtask
    task automatic s_line();
        active_power <= 24'h400000;
        wr(`AEA_IDX_ACC_MODE, 32'h00000080);
        wr(`AEA_IDX_EN_HIGH, 32'h00000004);
        wr(`AEA_IDX_HALF_CYC, 32'h00000002);
        zc(3);
        rd(`AEA_IDX_ST_HIGH);
        chk(r & 32'h00000004, 32'h00000004);
        chk({31'h00000000, measure_irq}, 32'h00000001);
        rd(`AEA_IDX_LINE_ENERGY);
        chk_rng(r[23:0], 9, 11);
        u_cpu.clear_flags(`AEA_IDX_ST_HIGH, 8'h04);
        repeat (3) @(posedge clock);
        chk({31'h00000000, measure_irq}, 32'h00000000);
        zc(2);
        rd(`AEA_IDX_LINE_ENERGY);
        chk_rng(r[23:0], 9, 11);
        wr(`AEA_IDX_HALF_CYC, 32'h00000002);
        rd(`AEA_IDX_LINE_ENERGY);
        chk(r, 32'h00000000);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        s_regs();
        s_accum();
        s_read_clear();
        s_no_load();
        s_pulse_wave();
        s_line();
        results();
    end
    // Cuts a hang short well above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            $display("Error at %0t: timeout", $time);
            results();
        end
    end
endmodule
